// ### logic/stat_dev.sv
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// R01: host sends read opcode, MSB first
// R02: host sends address then dummy byte
// R03: data out eight clocks, MSB first
// R04: chip select high floats output at once
// R05: output bit every clock after dummy byte
// R06: read address advances after each byte
// R07: first read byte on clocks 24 to 31
// R08: addresses seven upward return undefined bytes
// R09: read address wraps from FF to 00
// R10: three direct write opcodes, no address
// R11: volatile enable covers next direct write
// R12: host sends write enable before writes
// R13: direct write clears write enable latch
// R14: partial byte at release aborts write
// R15: second byte of 01h writes register two
// R16: indirect write, address picks register
// R17: indirect write needs write enable latch
// R18: extra data byte cancels indirect write
// R19: read addresses one to six map bytes
// R20: bad write address aborts, clears latch
// R21: sample rising edge, drive falling edge
// R22: ignore input during read, reset per frame
module stat_dev
  import stat_pkg::*;
(
  input  wire logic                  CLK_I,      // register side clock
  input  wire logic                  RESET_N_I,  // active low reset
  output logic [stat_pkg::STAT_W-1:0] STATUS_O,  // six status bytes
  spi_link_if.dev                    LINK        // serial link
);

  // ----------------------------------------------------------------
  // link domain storage
  // ----------------------------------------------------------------
  logic       in_frame_r;  // a rising edge was seen in this frame
  logic [2:0] bit_cnt_r;   // bit index within current byte
  logic [2:0] byte_cnt_r;  // completed bytes, saturating
  logic [6:0] sh_r;        // incoming bits of current byte
  logic [7:0] op_r;        // opcode byte
  logic [7:0] b1_r;        // address or first data byte
  logic [7:0] b2_r;        // second data byte
  logic [7:0] rd_addr_r;   // read pointer
  logic       tog_r;       // flips once at each frame start
  logic       so_r;        // serial output value
  logic       oe_n_r;      // serial output enable, low drives
  logic [2:0] nb;          // bit index, zero before first edge
  logic [2:0] nbyte;       // byte index, zero before first edge
  logic [7:0] byte_in;     // byte completed on this edge
  logic [7:0] rd_byte;     // byte under the read pointer

  // ----------------------------------------------------------------
  // register domain storage
  // ----------------------------------------------------------------
  logic [STAT_W-1:0] stat_r;    // status word
  logic              vwe_r;     // volatile write enable armed
  logic              seen_r;    // last frame toggle handled
  logic              cs_q_r;    // delayed synced chip select
  logic [1:0]        sync_q;    // {chip select, toggle} synced
  logic              frame_end; // one-cycle pulse per finished frame
  logic              whole;     // frame ended on a byte boundary
  logic              wr_en;     // any enable armed for a direct write

  // stale counts are masked until the frame's first edge
  assign nb      = in_frame_r ? bit_cnt_r : 3'h0;            // R22
  assign nbyte   = in_frame_r ? byte_cnt_r : 3'h0;           // R22
  assign byte_in = {sh_r, LINK.mosi};
  // status word is quiet during a frame, so it is read directly
  assign rd_byte = addr_ok(rd_addr_r)
                 ? stat_r[byte_pos(rd_addr_r) +: 8]          // R19
                 : UNDEF_BYTE;                               // R08

  // ----------------------------------------------------------------
  // frame marker: cleared the moment chip select rises
  // ----------------------------------------------------------------
  always_ff @(posedge LINK.sck or posedge LINK.cs_n)
  begin
    if (LINK.cs_n)
      in_frame_r <= 1'b0;                                    // R22
    else
      in_frame_r <= 1'b1;
  end

  // ----------------------------------------------------------------
  // input shifter on rising edges; results held after the frame
  // ----------------------------------------------------------------
  // the link clock stops between frames, so its reset is async
  always_ff @(posedge LINK.sck or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
    begin
      bit_cnt_r  <= 3'h0;
      byte_cnt_r <= 3'h0;
      sh_r       <= 7'h00;
      op_r       <= 8'h00;
      b1_r       <= 8'h00;
      b2_r       <= 8'h00;
      rd_addr_r  <= 8'h00;
      tog_r      <= 1'b0;
    end
    else
    begin
      if (!in_frame_r)
        tog_r <= ~tog_r;            // announce a new frame
      bit_cnt_r <= nb + 3'h1;                                // R21
      sh_r      <= byte_in[6:0];    // MSB arrives first      R01
      if (nb == 3'h7 && nbyte != PH_SAT)
        byte_cnt_r <= nbyte + 3'h1;
      else
        byte_cnt_r <= nbyte;
      if (nb == 3'h7)
      begin
        unique case (nbyte)
          3'h0:     op_r <= byte_in;                          // R01
          PH_ADDR:
          begin
            b1_r      <= byte_in;                            // R16
            rd_addr_r <= byte_in;                            // R02
          end
          PH_DATA2: b2_r <= byte_in;  // dummy on reads        R02
          default:
          begin
            // input bits during read-out are ignored          R22
            if (op_r == OP_RD_IND)
              rd_addr_r <= rd_addr_r + 8'h01;         // R06 R09
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // output driver on falling edges, floated by chip select
  // ----------------------------------------------------------------
  always_ff @(negedge LINK.sck or posedge LINK.cs_n)
  begin
    if (LINK.cs_n)
    begin
      so_r   <= 1'b0;
      oe_n_r <= 1'b1;                                        // R04
    end
    else if (in_frame_r && op_r == OP_RD_IND && nbyte >= PH_READ)
    begin
      so_r   <= rd_byte[3'h7 - nb];  // bit 7 on clock 24  R03 R07
      oe_n_r <= 1'b0;                                  // R05 R21
    end
    else
    begin
      so_r   <= 1'b0;   // command, address and dummy phases
      oe_n_r <= 1'b1;
    end
  end

  assign LINK.miso_d    = so_r;
  assign LINK.miso_oe_n = oe_n_r;

  // ----------------------------------------------------------------
  // frame end detection in the register domain
  // ----------------------------------------------------------------
  bit_sync2 #(
    .W       (2),
    .RST_VAL (2'b10)
  ) u_sync (
    .clk_i   (CLK_I),
    .rst_n_i (RESET_N_I),
    .d_i     ({LINK.cs_n, tog_r}),
    .q_o     (sync_q)
  );

  // a select pulse with no clock edge leaves the toggle alone
  assign frame_end = sync_q[1] & ~cs_q_r & (sync_q[0] != seen_r);
  assign whole     = (bit_cnt_r == 3'h0);                    // R14
  assign wr_en     = stat_r[WEL_BIT] | vwe_r;                // R11

  always_ff @(posedge CLK_I)
  begin
    if (!RESET_N_I)
    begin
      cs_q_r <= 1'b1;
      seen_r <= 1'b0;
    end
    else
    begin
      cs_q_r <= sync_q[1];
      if (frame_end)
        seen_r <= sync_q[0];
    end
  end

  // ----------------------------------------------------------------
  // commit of a finished frame; held bytes are stable by now
  // ----------------------------------------------------------------
  // a write that ends off a byte boundary changes nothing     R14
  always_ff @(posedge CLK_I)
  begin
    if (!RESET_N_I)
    begin
      stat_r <= {NUM_REGS{REG_RESET}};
      vwe_r  <= 1'b0;
    end
    else if (frame_end && whole)
    begin
      unique case (op_r)
        OP_WREN:
          if (byte_cnt_r == 3'h1)
            stat_r[WEL_BIT] <= 1'b1;                         // R12
        OP_VWREN:
          if (byte_cnt_r == 3'h1)
            vwe_r <= 1'b1;          // latch itself untouched   R11
        OP_WR_ONE, OP_WR_TWO, OP_WR_TRI:
          if (byte_cnt_r >= PH_DATA2)
          begin
            if (wr_en)
            begin
              if (op_r == OP_WR_ONE)
                stat_r[byte_pos(ADDR_FIRST) +: 8] <= b1_r;   // R10
              else if (op_r == OP_WR_TWO)
                stat_r[byte_pos(ADDR_TWO) +: 8] <= b1_r;     // R10
              else
                stat_r[byte_pos(ADDR_TRI) +: 8] <= b1_r;     // R10
              if (op_r == OP_WR_ONE && byte_cnt_r >= PH_READ)
                stat_r[byte_pos(ADDR_TWO) +: 8] <= b2_r;     // R15
            end
            stat_r[WEL_BIT] <= 1'b0;  // after any data write  R13
            vwe_r           <= 1'b0;                         // R11
          end
        OP_WR_IND:
          if (byte_cnt_r >= PH_DATA2)
          begin
            // bad address aborts but still drops the latch    R20
            if (addr_ok(b1_r) && byte_cnt_r == PH_READ
                && stat_r[WEL_BIT])                   // R17 R18
              stat_r[byte_pos(b1_r) +: 8] <= b2_r;           // R16
            if (byte_cnt_r >= PH_READ || !addr_ok(b1_r))
            begin
              stat_r[WEL_BIT] <= 1'b0;                       // R20
              vwe_r           <= 1'b0;
            end
          end
        default: ;  // reads and foreign opcodes leave state alone
      endcase
    end
  end

  assign STATUS_O = stat_r;

endmodule : stat_dev
`default_nettype wire

// ### logic/stat_pkg.sv
`default_nettype none
package stat_pkg;

  // ----------------------------------------------------------------
  // command opcodes
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_RD_IND = 8'h65; // indirect status read
  localparam logic [7:0] OP_WR_IND = 8'h71; // indirect status write
  localparam logic [7:0] OP_WR_ONE = 8'h01; // direct write, register one
  localparam logic [7:0] OP_WR_TWO = 8'h31; // direct write, register two
  localparam logic [7:0] OP_WR_TRI = 8'h11; // direct write, register three
  localparam logic [7:0] OP_WREN   = 8'h06; // ordinary write enable
  localparam logic [7:0] OP_VWREN  = 8'h50; // volatile write enable

  // ----------------------------------------------------------------
  // register map and field layout
  // ----------------------------------------------------------------
  localparam int         NUM_REGS   = 6;            // status bytes
  localparam int         STAT_W     = 8 * NUM_REGS; // whole status word
  localparam logic [7:0] ADDR_FIRST = 8'h01;        // status_byte_one
  localparam logic [7:0] ADDR_LAST  = 8'h06;        // status_byte_six
  localparam logic [7:0] ADDR_TWO   = 8'h02;        // status_byte_two
  localparam logic [7:0] ADDR_TRI   = 8'h03;        // status_byte_three
  localparam int         WEL_BIT    = 1;  // write_enable_latch in byte one
  localparam logic [7:0] REG_RESET  = 8'h00;        // every status byte
  localparam logic [7:0] UNDEF_BYTE = 8'h00;        // unimplemented addr

  // ----------------------------------------------------------------
  // frame phases and timing counts (CLK_I cycles)
  // ----------------------------------------------------------------
  localparam logic [2:0] PH_ADDR  = 3'h1; // byte index of address/data 1
  localparam logic [2:0] PH_DATA2 = 3'h2; // byte index of dummy/data 2
  localparam logic [2:0] PH_READ  = 3'h3; // first read-out byte index
  localparam logic [2:0] PH_SAT   = 3'h7; // byte counter saturates here
  localparam int         SCK_HALF = 4;    // host clock half period
  localparam int         CS_GAP   = 8;    // host idle time, cs high

  // ----------------------------------------------------------------
  // shared decoders
  // ----------------------------------------------------------------
  // true for the six implemented register addresses
  function automatic logic addr_ok(input logic [7:0] a);
    addr_ok = (a >= ADDR_FIRST) && (a <= ADDR_LAST);
  endfunction : addr_ok

  // bit offset of an implemented byte inside the status word
  function automatic logic [5:0] byte_pos(input logic [7:0] a);
    logic [2:0] idx;
    idx      = a[2:0] - 3'h1;
    byte_pos = {idx, 3'b000};
  endfunction : byte_pos

endpackage : stat_pkg
`default_nettype wire

// ### logic/spi_link_if.sv
`timescale 1ns/10ps
`default_nettype none
// serial link between host and status device
interface spi_link_if;
  logic sck;        // serial clock, made by the host
  logic cs_n;       // chip select, active low
  logic mosi;       // host to device data
  logic miso_d;     // device output value
  logic miso_oe_n;  // device output enable, low while driving
  wire  miso_line;  // resolved output wire

  // a pull-up holds the line high whenever the device lets go;
  // the host only samples it in data phases, so the level is harmless
  assign miso_line = miso_oe_n ? 1'b1 : miso_d;

  modport dev  (input sck, input cs_n, input mosi,
                output miso_d, output miso_oe_n);
  modport host (output sck, output cs_n, output mosi,
                input miso_line);
endinterface : spi_link_if
`default_nettype wire

// ### logic/bit_sync2.sv
`timescale 1ns/10ps
`default_nettype none
// two flip-flop synchroniser; first stage feeds only the second
module bit_sync2 #(
  parameter int           W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta_r; // metastable stage, read by q_o only

  // ----------------------------------------------------------------
  // synchronous reset to a constant
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      meta_r <= RST_VAL;
      q_o    <= RST_VAL;
    end
    else
    begin
      meta_r <= d_i;
      q_o    <= meta_r;
    end
  end
endmodule : bit_sync2
`default_nettype wire

// ### logic/stat_host.sv
`timescale 1ns/10ps
`default_nettype none
// host end: frames one command, mode 0, clock derived from CLK_I
module stat_host
  import stat_pkg::*;
#(
  parameter int HALF = stat_pkg::SCK_HALF, // CLK_I cycles per half
  parameter int GAP  = stat_pkg::CS_GAP    // idle cycles after frame
) (
  input  wire logic        CLK_I,       // system clock
  input  wire logic        RESET_N_I,   // active low reset
  input  wire logic        START_I,     // start a frame, while idle
  input  wire logic [31:0] TX_WORD_I,   // bytes to send, first in MSB
  input  wire logic [2:0]  TX_COUNT_I,  // bytes to send, 1..4
  input  wire logic [3:0]  RX_COUNT_I,  // bytes to read afterwards
  input  wire logic [2:0]  CUT_I,       // stray bits before release
  output logic             BUSY_O,      // frame in progress
  output logic [7:0]       RX_BYTE_O,   // received byte
  output logic             RX_VALID_O,  // pulse with RX_BYTE_O
  output logic             DONE_O,      // pulse at the end of a frame
  spi_link_if.host         LINK         // serial link
);

  typedef enum logic [1:0] {H_IDLE, H_LOW, H_HIGH, H_GAP} hstate_t;

  hstate_t     st_r;       // frame sequencer
  logic [7:0]  div_r;      // phase counter
  logic [7:0]  bit_r;      // bits completed in frame
  logic [7:0]  total_r;    // bits in this frame
  logic [7:0]  tx_bits_r;  // bits sent before read-out
  logic [31:0] tx_sh_r;    // outgoing bits, MSB first
  logic [6:0]  rx_sh_r;    // incoming bits of current byte
  logic        sck_r;      // serial clock, idle low
  logic        cs_n_r;     // chip select
  logic        mosi_r;     // serial data out
  logic        miso_s;     // synchronised serial data in
  logic [7:0]  rx_idx;     // bit index within read-out

  // the device output comes from another clock; two flops first
  bit_sync2 #(
    .W       (1),
    .RST_VAL (1'b0)
  ) u_miso (
    .clk_i   (CLK_I),
    .rst_n_i (RESET_N_I),
    .d_i     (LINK.miso_line),
    .q_o     (miso_s)
  );

  assign rx_idx = bit_r - tx_bits_r;

  // ----------------------------------------------------------------
  // frame sequencer
  // ----------------------------------------------------------------
  // sampling at the end of the high phase leaves room for the sync
  always_ff @(posedge CLK_I)
  begin
    if (!RESET_N_I)
    begin
      st_r       <= H_IDLE;
      div_r      <= 8'h00;
      bit_r      <= 8'h00;
      total_r    <= 8'h00;
      tx_bits_r  <= 8'h00;
      tx_sh_r    <= 32'h0000_0000;
      rx_sh_r    <= 7'h00;
      sck_r      <= 1'b0;
      cs_n_r     <= 1'b1;
      mosi_r     <= 1'b0;
      BUSY_O     <= 1'b0;
      RX_BYTE_O  <= 8'h00;
      RX_VALID_O <= 1'b0;
      DONE_O     <= 1'b0;
    end
    else
    begin
      RX_VALID_O <= 1'b0;
      DONE_O     <= 1'b0;
      unique case (st_r)
        H_IDLE:
          if (START_I)
          begin
            total_r   <= 8'({TX_COUNT_I, 3'b000})
                       + 8'({RX_COUNT_I, 3'b000}) + 8'(CUT_I);
            tx_bits_r <= 8'({TX_COUNT_I, 3'b000});
            tx_sh_r   <= TX_WORD_I;
            mosi_r    <= TX_WORD_I[31];  // first bit is the MSB R01
            cs_n_r    <= 1'b0;
            bit_r     <= 8'h00;
            div_r     <= 8'h00;
            BUSY_O    <= 1'b1;
            st_r      <= H_LOW;
          end
        H_LOW:
          if (div_r == 8'(HALF - 1))
          begin
            div_r <= 8'h00;
            sck_r <= 1'b1;  // device samples here
            st_r  <= H_HIGH;
          end
          else
            div_r <= div_r + 8'h01;
        H_HIGH:
          if (div_r == 8'(HALF - 1))
          begin
            div_r   <= 8'h00;
            sck_r   <= 1'b0;  // device updates its output here
            bit_r   <= bit_r + 8'h01;
            tx_sh_r <= {tx_sh_r[30:0], 1'b0};
            mosi_r  <= tx_sh_r[30];
            if (bit_r >= tx_bits_r)
            begin
              rx_sh_r <= {rx_sh_r[5:0], miso_s};
              if (rx_idx[2:0] == 3'h7)
              begin
                RX_BYTE_O  <= {rx_sh_r, miso_s};
                RX_VALID_O <= 1'b1;
              end
            end
            st_r <= (bit_r + 8'h01 == total_r) ? H_GAP : H_LOW;
          end
          else
            div_r <= div_r + 8'h01;
        H_GAP:
        begin
          div_r <= div_r + 8'h01;
          if (div_r == 8'(HALF - 1))
            cs_n_r <= 1'b1;  // release after a low half
          if (div_r == 8'(HALF + GAP - 1))
          begin
            BUSY_O <= 1'b0;
            DONE_O <= 1'b1;
            st_r   <= H_IDLE;
          end
        end
      endcase
    end
  end

  assign LINK.sck  = sck_r;
  assign LINK.cs_n = cs_n_r;
  assign LINK.mosi = mosi_r;

endmodule : stat_host
`default_nettype wire

// ### verification/stat_link_chk.sv
`timescale 1ns/10ps
`default_nettype none
// watches the serial link from the system clock side
module stat_link_chk (
  input wire logic CLK_I,      // sampling clock
  input wire logic RESET_N_I,  // active low reset
  input wire logic sck,        // serial clock
  input wire logic cs_n,       // chip select, active low
  input wire logic mosi,       // host to device
  input wire logic miso_d,     // device output value
  input wire logic miso_oe_n   // low while the device drives
);
  // ----------------------------------------------------------------
  // frame tracking
  // ----------------------------------------------------------------
  logic       sck_q_r;  // sck one cycle ago
  logic [7:0] cnt_r;    // rising sck edges in this frame
  logic [7:0] sh_r;     // bits taken so far
  logic [7:0] op_r;     // opcode, valid once cnt_r reaches 8
  wire        rise;     // sck rose since the last sample
  assign rise = sck && !sck_q_r;
  // edge detector
  always_ff @(posedge CLK_I)
    sck_q_r <= RESET_N_I ? sck : 1'b0;
  // edge count; a released chip select restarts the frame
  always_ff @(posedge CLK_I)
    if (!RESET_N_I || cs_n)
      cnt_r <= 8'h00;
    else if (rise)
      cnt_r <= cnt_r + 8'h01;
  // opcode capture, msb first
  always_ff @(posedge CLK_I)
    if (!RESET_N_I)
      sh_r <= 8'h00;
    else if (rise)
      sh_r <= {sh_r[6:0], mosi};
  // opcode latched at the eighth edge
  always_ff @(posedge CLK_I)
    if (!RESET_N_I)
      op_r <= 8'h00;
    else if (rise && cnt_r == 8'h07)
      op_r <= {sh_r[6:0], mosi};
  // ----------------------------------------------------------------
  // link properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RESET_N_I);
  a_float_on_release: assert property (
    cs_n |-> miso_oe_n) else $error("output driven while deselected");
  a_drive_on_fall: assert property (
    (!miso_oe_n && $past(!miso_oe_n) && $changed(miso_d)) |-> $fell(sck))
    else $error("output moved off a falling edge");
  a_quiet_before_data: assert property (
    !miso_oe_n |-> cnt_r >= 8'h18) else $error("output before clock 24");
  a_drive_in_read: assert property (
    (!cs_n && op_r == 8'h65 && cnt_r >= 8'h19) |-> !miso_oe_n)
    else $error("read data not driven");
  a_quiet_in_write: assert property (
    (op_r != 8'h65 && cnt_r >= 8'h08) |-> miso_oe_n)
    else $error("output driven outside a read");
  a_sck_idle_low: assert property (
    cs_n |-> !sck) else $error("clock high while deselected");
  a_mosi_steady: assert property (
    (sck && $past(sck)) |-> $stable(mosi)) else $error("input moved");
  a_cs_gap: assert property (
    $rose(cs_n) |=> cs_n [*4]) else $error("deselect gap too short");
endmodule : stat_link_chk
`default_nettype wire

// ### verification/status_register_access_cmds_bench.sv
`timescale 1ns/10ps
`default_nettype none
module status_register_access_cmds_bench;
  import stat_pkg::*;
  logic        clk, rst_n, start, busy, rx_v, done;
  logic [31:0] tx_w;             // bytes to send
  logic [2:0]  tx_n, cut;        // byte count, stray bits
  logic [3:0]  rx_n;             // bytes to read
  logic [7:0]  rx_b;             // received byte
  logic [STAT_W-1:0] status, ex; // seen and expected word
  logic [7:0]  rxq[$];           // bytes of the last frame
  int          n_fail, checks_done;
  spi_link_if  link ();
  stat_dev u_stat_dev (.CLK_I(clk), .RESET_N_I(rst_n),
    .STATUS_O(status), .LINK(link));
  stat_host #(.HALF(SCK_HALF), .GAP(CS_GAP)) u_stat_host (.CLK_I(clk),
    .RESET_N_I(rst_n), .START_I(start), .TX_WORD_I(tx_w),
    .TX_COUNT_I(tx_n), .RX_COUNT_I(rx_n), .CUT_I(cut), .BUSY_O(busy),
    .RX_BYTE_O(rx_b), .RX_VALID_O(rx_v), .DONE_O(done), .LINK(link));
  stat_link_chk u_stat_link_chk (.CLK_I(clk), .RESET_N_I(rst_n),
    .sck(link.sck), .cs_n(link.cs_n), .mosi(link.mosi),
    .miso_d(link.miso_d), .miso_oe_n(link.miso_oe_n));
  // 100 ns system clock
  always #50 clk = ~clk;
  // collect read bytes where the pulse has settled
  always @(negedge clk)
    if (rx_v === 1'b1)
      rxq.push_back(rx_b);
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [47:0] seen, input logic [47:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : finish_test
  // one whole frame; waits for the host to report the end
  task automatic frame(input logic [31:0] w, input logic [2:0] n,
                       input logic [3:0] r, input logic [2:0] c);
    int k;
    rxq.delete();
    @(posedge clk);
    tx_w <= w;
    tx_n <= n;
    rx_n <= r;
    cut <= c;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    @(negedge clk);
    check(48'(busy), 48'h1);
    for (k = 0; k < 3000; k++)
    begin
      @(negedge clk);
      if (done === 1'b1)
        break;
    end
    if (k >= 3000)
    begin
      n_fail++;
      finish_test();
    end
    check(48'(busy), 48'h0);
    // commit lands a few cycles after release
    repeat (4) @(negedge clk);
  endtask : frame
  task automatic wren;
    frame({OP_WREN, 24'h0}, 3'h1, 4'h0, 3'h0);
  endtask : wren
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic s_direct;
    wren();
    ex[1] = 1'b1;
    check(status, ex);
    frame({OP_WR_ONE, 8'hF0, 8'h5A, 8'h00}, 3'h3, 4'h0, 3'h0);
    ex[15:0] = 16'h5AF0;
    check(status, ex);
    wren();
    frame({OP_WR_TRI, 8'h0C, 16'h0}, 3'h2, 4'h0, 3'h0);
    ex[23:16] = 8'h0C;
    check(status, ex);
  endtask : s_direct
  // indirect writes: no enable, good, bad address, extra byte
  task automatic s_indirect;
    frame({OP_WR_IND, 8'h05, 8'h3C, 8'h00}, 3'h3, 4'h0, 3'h0);
    check(status, ex);
    wren();
    frame({OP_WR_IND, 8'h04, 8'hA5, 8'h00}, 3'h3, 4'h0, 3'h0);
    ex[31:24] = 8'hA5;
    check(status, ex);
    wren();
    frame({OP_WR_IND, 8'h07, 8'h11, 8'h00}, 3'h3, 4'h0, 3'h0);
    ex[1] = 1'b0;
    check(status, ex);
    wren();
    frame({OP_WR_IND, 8'h00, 8'h11, 8'h00}, 3'h3, 4'h0, 3'h0);
    check(status, ex);
    wren();
    frame({OP_WR_IND, 8'h03, 8'h22, 8'h33}, 3'h4, 4'h0, 3'h0);
    check(status, ex);
  endtask : s_indirect
  // release off a byte boundary changes nothing, latch kept
  task automatic s_cut;
    wren();
    frame({OP_WR_TRI, 8'h77, 16'h0}, 3'h2, 4'h0, 3'h3);
    ex[1] = 1'b1;
    check(status, ex);
    frame({OP_WR_TWO, 8'h99, 16'h0}, 3'h2, 4'h0, 3'h0);
    ex[15:8] = 8'h99;
    ex[1] = 1'b0;
    check(status, ex);
  endtask : s_cut
  // volatile enable: no latch, one write only
  task automatic s_volatile;
    frame({OP_VWREN, 24'h0}, 3'h1, 4'h0, 3'h0);
    check(status, ex);
    frame({OP_WR_TWO, 8'h66, 16'h0}, 3'h2, 4'h0, 3'h0);
    ex[15:8] = 8'h66;
    check(status, ex);
    frame({OP_WR_TWO, 8'h44, 16'h0}, 3'h2, 4'h0, 3'h0);
    check(status, ex);
    frame({OP_VWREN, 24'h0}, 3'h1, 4'h0, 3'h0);
    frame({OP_WR_ONE, 8'hC8, 16'h0}, 3'h2, 4'h0, 3'h0);
    ex[7:0] = 8'hC8;
    check(status, ex);
  endtask : s_volatile
  // continuous read, wrap, and a release in mid-byte
  task automatic s_read;
    frame({OP_RD_IND, 8'h01, 16'h0}, 3'h3, 4'h8, 3'h0);
    check(48'(rxq.size()), 48'h8);
    for (int i = 0; i < 6; i++)
      check(48'(rxq[i]), 48'(ex[8*i +: 8]));
    check(48'(rxq[6]), 48'(UNDEF_BYTE));
    frame({OP_RD_IND, 8'hFE, 16'h0}, 3'h3, 4'h4, 3'h0);
    check(48'(rxq[2]), 48'(UNDEF_BYTE));
    check(48'(rxq[3]), 48'(ex[7:0]));
    frame({OP_RD_IND, 8'h02, 16'h0}, 3'h3, 4'h0, 3'h4);
    check(48'(rxq.size()), 48'h0);
    check(48'(link.miso_oe_n), 48'h1);
    check(status, ex);
  endtask : s_read
  initial
  begin
    clk = 1'b0;
    rst_n = 1'b0;
    start = 1'b0;
    tx_w = 32'h0;
    tx_n = 3'h1;
    rx_n = 4'h0;
    cut = 3'h0;
    ex = '0;
    n_fail = 0;
    checks_done = 0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(negedge clk);
    check(status, ex);
    s_direct();
    s_indirect();
    s_cut();
    s_volatile();
    s_read();
    finish_test();
  end
endmodule : status_register_access_cmds_bench
`default_nettype wire
